/* cmd_decoder_pkg.sv */
package cmd_decoder_pkg;

	localparam int CMD_W = 16;
	localparam logic [15:0] CMD_WORD_RESET = 16'h0000;
	localparam int DECADE_MAX = 999;

	// state-machine profile bit positions
	localparam int SM_SWITCH_ON_BIT = 0;
	localparam int SM_VOLTAGE_BIT = 1;
	localparam int SM_QUICK_STOP_BIT = 2;
	localparam int SM_ENABLE_OP_BIT = 3;
	localparam int SM_FAULT_RESET_BIT = 7;
	localparam int SM_HALT_BIT = 8;
	localparam int SM_ASSIGN_LO = 11;
	localparam logic [15:0] SM_RESERVED_MASK = 16'h0670;
	localparam logic [15:0] SM_ASSIGN_MASK = 16'hF800;

	// i/o profile bit positions
	localparam int IO_FWD_LEVEL_BIT = 0;
	localparam int IO_RUN_AUTH_BIT = 0;
	localparam int IO_FWD_EDGE_BIT = 1;
	localparam logic [15:0] IO2_ASSIGN_MASK = 16'hFFFE;
	localparam logic [15:0] IO3_ASSIGN_MASK = 16'hFFFC;

	typedef enum logic [1:0] {
		SRC_TERMINALS,
		SRC_DISPLAY_TERMINAL,
		SRC_SERIAL_NETWORK,
		SRC_FIELDBUS_MODULE
	} cmd_source_e;

	localparam cmd_source_e SOURCE_RESET = SRC_TERMINALS;

	typedef enum logic [1:0] {
		MODE_STATE_MACHINE,
		MODE_IO_2WIRE,
		MODE_IO_3WIRE
	} ctrl_mode_e;

	typedef struct packed {
		logic switch_on;
		logic voltage_enable;
		logic quick_stop;
		logic enable_operation;
		logic fault_reset;
		logic halt;
	} sm_cmd_s;

	typedef struct packed {
		logic forward_level;
		logic run_authorized;
		logic forward_start;
		logic stop_forced;
	} io_cmd_s;

	typedef struct packed {
		logic [9:0] wh;
		logic [9:0] kwh;
		logic [9:0] mwh;
		logic [9:0] gwh;
	} energy_s;

endpackage

/* cmd_master_model.sv */
`timescale 1ns/1ps
module cmd_master_model
	import cmd_decoder_pkg::*;
(
	input wire logic sys_clk,
	output logic [15:0] cmd_wr_data,
	output logic cmd_wr_en,
	output cmd_source_e cmd_wr_source
);
	initial begin
		cmd_wr_data = 16'h0000;
		cmd_wr_en = 1'b0;
		cmd_wr_source = SRC_TERMINALS;
	end
	// reserved bits go out as given, so a scenario can set them on purpose
	task automatic put(input logic [15:0] d, input cmd_source_e s);
		@(negedge sys_clk);
		cmd_wr_data <= d;
		cmd_wr_source <= s;
		cmd_wr_en <= 1'b1;
		@(negedge sys_clk);
		cmd_wr_en <= 1'b0;
		// stale data is inverted so nothing relies on a held bus
		cmd_wr_data <= ~d;
	endtask
endmodule

/* dcw_check_properties.sv */
`timescale 1ns/1ps
module dcw_check
	import cmd_decoder_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [15:0] cmd_wr_data,
	input wire logic cmd_wr_en,
	input cmd_source_e source_select,
	input wire logic source_select_wr,
	input wire logic fieldbus_present,
	input ctrl_mode_e ctrl_mode,
	input wire logic energy_wh_tick,
	input logic [15:0] drive_command_word,
	input cmd_source_e active_source,
	input logic word_channel_active,
	input sm_cmd_s sm_cmd,
	input io_cmd_s io_cmd,
	input energy_s energy
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	wire sm_w = cmd_wr_en && ctrl_mode == MODE_STATE_MACHINE;
	AST_SM_LEVELS: assert property (
		sm_w |=> sm_cmd.switch_on == $past(cmd_wr_data[0]) &&
		sm_cmd.voltage_enable == $past(cmd_wr_data[1]) &&
		sm_cmd.quick_stop != $past(cmd_wr_data[2]) &&
		sm_cmd.enable_operation == $past(cmd_wr_data[3]) &&
		sm_cmd.halt == $past(cmd_wr_data[8])) else $error("sm levels");
	AST_FAULT_EDGE: assert property (
		sm_cmd.fault_reset |-> drive_command_word[7] &&
		!$past(drive_command_word[7]) ##1 !sm_cmd.fault_reset)
		else $error("fault reset not a single edge pulse");
	AST_IO_OFF: assert property (
		ctrl_mode == MODE_STATE_MACHINE [*2] |-> io_cmd == 4'h0)
		else $error("io command in state machine mode");
	AST_FWD_LEVEL: assert property (
		io_cmd.forward_level |-> drive_command_word[0] &&
		word_channel_active) else $error("forward level wrong");
	AST_FWD_START: assert property (
		io_cmd.forward_start |-> drive_command_word[1:0] == 2'h3 &&
		!$past(drive_command_word[1]) ##1 !io_cmd.forward_start)
		else $error("forward start not on rising edge");
	AST_RUN_AUTH: assert property (
		io_cmd.run_authorized |-> drive_command_word[0] &&
		word_channel_active) else $error("run authorized wrong");
	AST_FB_REFUSE: assert property (
		source_select_wr && source_select == SRC_FIELDBUS_MODULE &&
		!fieldbus_present |=> active_source != SRC_FIELDBUS_MODULE)
		else $error("fieldbus channel taken without module");
	AST_WH_CARRY: assert property (
		energy_wh_tick && energy.wh == 10'h3E7 && energy.kwh < 10'h3E7
		|=> energy.wh == 10'h000 && energy.kwh == $past(energy.kwh) +
		10'h001) else $error("wh carry wrong");
	cover property (sm_cmd.fault_reset);
	cover property (io_cmd.forward_start);
	cover property (active_source == SRC_FIELDBUS_MODULE);
endmodule
bind drive_command_word_decoder dcw_check u_chk(.sys_clk(sys_clk),
	.resetn(resetn), .cmd_wr_data(cmd_wr_data), .cmd_wr_en(cmd_wr_en),
	.source_select(source_select), .source_select_wr(source_select_wr),
	.fieldbus_present(fieldbus_present), .ctrl_mode(ctrl_mode),
	.energy_wh_tick(energy_wh_tick), .active_source(active_source),
	.drive_command_word(drive_command_word), .sm_cmd(sm_cmd),
	.word_channel_active(word_channel_active), .io_cmd(io_cmd),
	.energy(energy));

/* drive_command_word_decoder.sv */
`timescale 1ns/1ps
// Summary of operation
// - energy shown as Wh/kWh/MWh/GWh fields, 0-999
// - one command channel selected; terminals default
// - fieldbus channel valid only with module present
// - non-I/O control mode uses state-machine layout
// - state machine bit 0 high requests switch-on
// - bit 1 low disables voltage
// - bit 2 low requests quick stop
// - bit 3 high enables operation (run)
// - fault reset on bit 7 rising edge only
// - bit 8 high halts, stays operation enabled
// - bits 4-6,9,10 zero (not enforced: ignored by decode, kept in the word); 11-15 assignable
// - 2-wire bit 0 is forward level; others assignable
// - 2-wire bit 0 fixed, not reassignable
// - fixed I/O bits act only on active channel
// - 3-wire bit 0 is run authorization
// - 3-wire forward starts on bit 1 rising edge
// - 3-wire bits 0,1 fixed; 2-15 assignable
module drive_command_word_decoder
	import cmd_decoder_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [15:0] cmd_wr_data,
	input wire logic cmd_wr_en,
	input cmd_source_e cmd_wr_source,
	input cmd_source_e source_select,
	input wire logic source_select_wr,
	input wire logic fieldbus_present,
	input ctrl_mode_e ctrl_mode,
	input wire logic energy_wh_tick,
	output logic [15:0] drive_command_word,
	output cmd_source_e active_source,
	output logic word_channel_active,
	output sm_cmd_s sm_cmd,
	output io_cmd_s io_cmd,
	output logic [15:0] assignable_bits,
	output energy_s energy
);

	typedef struct packed {
		logic [15:0] word;
		cmd_source_e word_source;
		cmd_source_e source;
		logic fault_prev;
		logic fwd_prev;
		logic word_seen;
		sm_cmd_s sm;
		io_cmd_s io;
		logic [15:0] assign_bits;
		logic chan_active;
	} state_s;

	state_s state_reg;
	state_s state_next;
	logic [1:0] rst_sync;
	logic rst_n;

	// reset released through two flops, asserted at once
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	function automatic logic source_ok(input cmd_source_e s,
		input logic fb_present);
		case (s)
			SRC_FIELDBUS_MODULE: source_ok = fb_present;
			SRC_TERMINALS,
			SRC_DISPLAY_TERMINAL,
			SRC_SERIAL_NETWORK: source_ok = 1'b1;
			default: source_ok = 1'b0;
		endcase
	endfunction

	logic [15:0] w;
	logic active;
	logic fault_rise;
	logic fwd_rise;

	always_comb begin
		state_next = state_reg;
		w = state_reg.word;
		if (cmd_wr_en) begin
			w = cmd_wr_data;
			state_next.word = cmd_wr_data;
			state_next.word_source = cmd_wr_source;
			state_next.word_seen = 1'b1;
		end
		// a bad selection is refused, the previous channel stays
		if (source_select_wr && source_ok(source_select, fieldbus_present)) begin
			state_next.source = source_select;
		end
		// losing the module drops the fieldbus channel back to terminals
		if (state_next.source == SRC_FIELDBUS_MODULE && !fieldbus_present) begin
			state_next.source = SOURCE_RESET;
		end
		active = state_reg.word_seen
			&& (state_next.word_source == state_next.source)
			&& source_ok(state_next.source, fieldbus_present);
		state_next.chan_active = active;
		// previous levels always track the word, so edges fire once
		fault_rise = w[SM_FAULT_RESET_BIT] && !state_reg.fault_prev;
		fwd_rise = w[IO_FWD_EDGE_BIT] && !state_reg.fwd_prev;
		state_next.fault_prev = w[SM_FAULT_RESET_BIT];
		state_next.fwd_prev = w[IO_FWD_EDGE_BIT];
		state_next.sm = '0;
		state_next.io = '0;
		state_next.assign_bits = 16'h0000;
		case (ctrl_mode)
			MODE_IO_2WIRE: begin
				// bit 0 is never passed as assignable
				state_next.io.forward_level =
					active && w[IO_FWD_LEVEL_BIT];
				state_next.assign_bits = w & IO2_ASSIGN_MASK;
			end
			MODE_IO_3WIRE: begin
				state_next.io.run_authorized =
					active && w[IO_RUN_AUTH_BIT];
				state_next.io.stop_forced =
					active && !w[IO_RUN_AUTH_BIT];
				state_next.io.forward_start =
					active && w[IO_RUN_AUTH_BIT] && fwd_rise;
				state_next.assign_bits = w & IO3_ASSIGN_MASK;
			end
			MODE_STATE_MACHINE: begin
				state_next.sm.switch_on = w[SM_SWITCH_ON_BIT];
				state_next.sm.voltage_enable = w[SM_VOLTAGE_BIT];
				state_next.sm.quick_stop = !w[SM_QUICK_STOP_BIT];
				state_next.sm.enable_operation = w[SM_ENABLE_OP_BIT];
				state_next.sm.fault_reset = fault_rise;
				state_next.sm.halt = w[SM_HALT_BIT];
				// reserved bits 4-6,9,10 are masked out here
				state_next.assign_bits = w & SM_ASSIGN_MASK;
			end
			default: begin
				// any other mode code still means the state-machine layout
				state_next.sm.switch_on = w[SM_SWITCH_ON_BIT];
				state_next.sm.voltage_enable = w[SM_VOLTAGE_BIT];
				state_next.sm.quick_stop = !w[SM_QUICK_STOP_BIT];
				state_next.sm.enable_operation = w[SM_ENABLE_OP_BIT];
				state_next.sm.fault_reset = fault_rise;
				state_next.sm.halt = w[SM_HALT_BIT];
				state_next.assign_bits = w & SM_ASSIGN_MASK;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '{
				word: CMD_WORD_RESET,
				word_source: SOURCE_RESET,
				source: SOURCE_RESET,
				fault_prev: 1'b0,
				fwd_prev: 1'b0,
				word_seen: 1'b0,
				sm: '0,
				io: '0,
				assign_bits: 16'h0000,
				chan_active: 1'b0
			};
		end else begin
			state_reg <= state_next;
		end
	end

	energy_decades #(
		.FIELD_W(10)
	) u_energy (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wh_tick(energy_wh_tick),
		.energy(energy)
	);

	assign drive_command_word = state_reg.word;
	assign active_source = state_reg.source;
	assign word_channel_active = state_reg.chan_active;
	assign sm_cmd = state_reg.sm;
	assign io_cmd = state_reg.io;
	assign assignable_bits = state_reg.assign_bits;

endmodule

/* energy_decades.sv */
`timescale 1ns/1ps
module energy_decades
	import cmd_decoder_pkg::*;
#(
	parameter int FIELD_W = 10
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wh_tick,
	output energy_s energy
);

	typedef struct packed {
		energy_s cnt;
	} state_s;

	state_s state_reg;
	state_s state_next;

	function automatic logic at_max(input logic [9:0] v);
		at_max = (v == 10'(DECADE_MAX));
	endfunction

	// each field rolls 999 -> 0 and carries; with every field at 999 the whole count holds
	always_comb begin
		state_next = state_reg;
		if (wh_tick) begin
			if (!at_max(state_reg.cnt.wh)) begin
				state_next.cnt.wh = state_reg.cnt.wh + 10'h001;
			end else begin
				state_next.cnt.wh = 10'h000;
				if (!at_max(state_reg.cnt.kwh)) begin
					state_next.cnt.kwh = state_reg.cnt.kwh + 10'h001;
				end else begin
					state_next.cnt.kwh = 10'h000;
					if (!at_max(state_reg.cnt.mwh)) begin
						state_next.cnt.mwh = state_reg.cnt.mwh + 10'h001;
					end else begin
						state_next.cnt.mwh = 10'h000;
						if (!at_max(state_reg.cnt.gwh)) begin
							state_next.cnt.gwh = state_reg.cnt.gwh + 10'h001;
						end else begin
							state_next.cnt = state_reg.cnt;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign energy = state_reg.cnt;

endmodule

/* test_drive_command_word_decoder.sv */
`timescale 1ns/1ps
module test_drive_command_word_decoder
	import cmd_decoder_pkg::*;
;
	logic sys_clk = 1'b0, resetn = 1'b0, source_select_wr = 1'b0;
	logic fieldbus_present = 1'b0, energy_wh_tick = 1'b0, cmd_wr_en;
	logic word_channel_active;
	logic [15:0] cmd_wr_data, drive_command_word, assignable_bits;
	cmd_source_e cmd_wr_source, active_source;
	cmd_source_e source_select = SRC_TERMINALS;
	ctrl_mode_e ctrl_mode = MODE_STATE_MACHINE;
	sm_cmd_s sm_cmd;
	io_cmd_s io_cmd;
	energy_s energy;
	int n_fail = 0, comparisons = 0, cyc = 0;
	always #2.5 sys_clk = ~sys_clk;
	cmd_master_model master(.sys_clk(sys_clk), .cmd_wr_data(cmd_wr_data),
		.cmd_wr_en(cmd_wr_en), .cmd_wr_source(cmd_wr_source));
	drive_command_word_decoder uut(.sys_clk(sys_clk), .resetn(resetn),
		.cmd_wr_data(cmd_wr_data), .cmd_wr_en(cmd_wr_en),
		.cmd_wr_source(cmd_wr_source), .source_select(source_select),
		.source_select_wr(source_select_wr), .ctrl_mode(ctrl_mode),
		.fieldbus_present(fieldbus_present), .energy(energy),
		.energy_wh_tick(energy_wh_tick), .active_source(active_source),
		.drive_command_word(drive_command_word), .sm_cmd(sm_cmd),
		.word_channel_active(word_channel_active), .io_cmd(io_cmd),
		.assignable_bits(assignable_bits));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic sel(input cmd_source_e s);
		@(negedge sys_clk);
		source_select <= s;
		source_select_wr <= 1'b1;
		@(negedge sys_clk);
		source_select_wr <= 1'b0;
	endtask
	task automatic test_done;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			test_done;
		end
	end
	initial begin
		repeat (10) @(negedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(negedge sys_clk);
		chk(active_source, SRC_TERMINALS);
		// code 3 must decode exactly like the state machine code
		for (int m = 0; m < 4; m += 3) begin
			ctrl_mode <= ctrl_mode_e'(m[1:0]);
			master.put(16'h0000, SRC_TERMINALS);
			chk(sm_cmd, 16'h0008);
			master.put(16'h0080, SRC_TERMINALS);
			chk(sm_cmd.fault_reset, 1'b1);
			@(negedge sys_clk);
			chk(sm_cmd.fault_reset, 1'b0);
			master.put(16'h0080, SRC_TERMINALS);
			chk(sm_cmd.fault_reset, 1'b0);
			chk(drive_command_word, 16'h0080);
			master.put(16'hF77F, SRC_TERMINALS);
			chk(sm_cmd, 16'h0035);
			chk(assignable_bits, 16'hF000);
			chk(io_cmd, 16'h0000);
		end
		$display("state machine test done");
		ctrl_mode <= MODE_IO_2WIRE;
		master.put(16'h0001, SRC_TERMINALS);
		chk(io_cmd.forward_level, 1'b1);
		chk(assignable_bits, 16'h0000);
		chk(sm_cmd, 16'h0000);
		master.put(16'hFFFF, SRC_SERIAL_NETWORK);
		chk(word_channel_active, 1'b0);
		chk(io_cmd.forward_level, 1'b0);
		$display("2-wire test done");
		ctrl_mode <= MODE_IO_3WIRE;
		master.put(16'h0002, SRC_TERMINALS);
		chk(io_cmd.run_authorized, 1'b0);
		chk(io_cmd.stop_forced, 1'b1);
		master.put(16'h0001, SRC_TERMINALS);
		chk(io_cmd.forward_start, 1'b0);
		master.put(16'h0007, SRC_TERMINALS);
		chk(io_cmd.forward_start, 1'b1);
		chk(assignable_bits, 16'h0004);
		chk(drive_command_word, 16'h0007);
		@(negedge sys_clk);
		chk(io_cmd.forward_start, 1'b0);
		chk(io_cmd.run_authorized, 1'b1);
		$display("3-wire test done");
		sel(SRC_FIELDBUS_MODULE);
		chk(active_source, SRC_TERMINALS);
		fieldbus_present <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			sel(cmd_source_e'(s[1:0]));
			chk(active_source, 16'(s));
		end
		fieldbus_present <= 1'b0;
		repeat (2) @(negedge sys_clk);
		chk(active_source, SRC_TERMINALS);
		$display("source test done");
		energy_wh_tick <= 1'b1;
		repeat (1000) @(negedge sys_clk);
		energy_wh_tick <= 1'b0;
		chk(energy.wh, 16'h0000);
		chk(energy.kwh, 16'h0001);
		chk(energy.mwh, 16'h0000);
		chk(energy.gwh, 16'h0000);
		$display("energy test done");
		test_done;
	end
endmodule
